/* File: verilog/queue_housekeeping.sv */
// queue system housekeeping: init, aging, super priority, copies, statistics
`timescale 1ns/1ns
`include "qhk_defs.svh"
module queue_housekeeping (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic MEMORY_ENABLE,
	input wire logic MEMORY_INIT_SET,
	output logic MEMORY_INIT,
	input wire logic CORE_ENABLE,
	input wire logic [3:0] PORT_SWITCHING_ENABLE,
	input wire logic [15:0] AGING_PERIOD,
	input wire logic [3:0] AGING_CHECK_DISABLE,
	input wire logic FLUSH_AS_STALE_ENABLE,
	output logic AGE_TICK,
	output logic [2:0] AGE_EPOCH,
	input wire logic [1:0] SCHED_PORT,
	input wire logic [7:0] QUEUE_PENDING,
	input wire logic [1:0] SP_PENDING,
	input wire logic SHAPER_OPEN,
	output qhk_pkg::sel_kind_t SEL_KIND,
	output logic [2:0] SEL_QUEUE,
	output logic SHAPER_CHARGE,
	input wire logic INJ_VALID,
	input wire logic INJ_SUPER_PRIORITY_FLAG,
	input wire logic [1:0] INJ_DROP_PRECEDENCE,
	output logic INJ_TO_SUPER,
	output logic INJ_SP_QUEUE,
	input wire logic COPY_VALID,
	input wire logic [1:0] COPY_PORT,
	input wire logic [2:0] COPY_EXTRACT_QUEUE,
	input wire logic [2:0] COPY_CFG_CLASS,
	input wire logic COPY_LEARNALL,
	input wire logic [13:0] COPY_LEN,
	input wire logic [3:0] CPU_COPY_CLASS_SELECT,
	input wire logic [3:0] LEARNALL_TRUNCATE_ENABLE,
	output logic [2:0] COPY_CLASS,
	output logic [13:0] COPY_OUT_LEN,
	input wire qhk_pkg::frame_event_t RX_EV,
	input wire qhk_pkg::frame_event_t DISCARD_EV,
	input wire logic [1:0] DISCARD_EGRESS_PORT,
	input wire logic DISCARD_REACHED_NONE,
	input wire logic DISCARD_IS_COPY,
	input wire logic DROP_COUNT_EGRESS,
	input wire logic TAIL_DROP_VALID,
	input wire logic [1:0] TAIL_DROP_PORT,
	input wire qhk_pkg::frame_event_t DEQ_EV,
	input wire logic [2:0] DEQ_EPOCH,
	output logic DEQ_SEND,
	output logic DEQ_DISCARD,
	input wire qhk_pkg::frame_event_t FLUSH_EV,
	input wire qhk_pkg::frame_event_t ABORT_EV,
	input wire logic [3:0] PRECEDENCE_TO_COLOR_MAP,
	input wire logic [3:0] STAT_VIEW,
	input wire logic STAT_CLEAR,
	input wire logic SERVICE_FRAMES_ONLY,
	input wire logic [9:0] WINDOW_ADDR,
	output logic [31:0] WINDOW_DATA
);
	logic init_busy;
	logic [3:0] init_idx;
	logic tick;
	logic [2:0] epoch;
	logic run;

	mem_init u_init (
		.clk(CLK),
		.arst_n(ARST_N),
		.memory_enable(MEMORY_ENABLE),
		.init_set(MEMORY_INIT_SET),
		.init_busy(init_busy),
		.init_idx(init_idx)
	);

	age_tick u_age (
		.clk(CLK),
		.arst_n(ARST_N),
		.aging_period(AGING_PERIOD),
		.tick(tick),
		.epoch(epoch)
	);

	assign MEMORY_INIT = init_busy; // [R03]
	assign AGE_TICK = tick;
	assign AGE_EPOCH = epoch; // [R06]
	// scheduling, dequeue and counting wait until init has finished and software raised core enable
	assign run = CORE_ENABLE && !init_busy; // [R02]

	// scheduling pick for one port at a time
	always_comb begin
		SEL_KIND = qhk_pkg::SEL_NONE;
		SEL_QUEUE = 3'h0;
		if (run && PORT_SWITCHING_ENABLE[SCHED_PORT]) begin // [R04]
			if (SP_PENDING[0]) begin
				SEL_KIND = qhk_pkg::SEL_SP0; // [R08] [R09]
			end else if (SHAPER_OPEN && SP_PENDING[1]) begin
				SEL_KIND = qhk_pkg::SEL_SP1; // [R08] [R09]
			end else if (SHAPER_OPEN && QUEUE_PENDING != 8'h00) begin
				SEL_KIND = qhk_pkg::SEL_NORMAL;
				for (int q = 0; q < 8; q++) begin
					if (QUEUE_PENDING[q]) begin
						SEL_QUEUE = 3'(q);
					end
				end
			end
		end
		SHAPER_CHARGE = (SEL_KIND == qhk_pkg::SEL_SP1) || (SEL_KIND == qhk_pkg::SEL_NORMAL); // [R09]
	end

	// registered per-frame decisions
	logic inj_super_ff, nxt_inj_super;
	logic inj_q_ff, nxt_inj_q;
	logic [2:0] cls_ff, nxt_cls;
	logic [13:0] len_ff, nxt_len;
	logic send_ff, nxt_send;
	logic drop_ff, nxt_drop;
	logic aged;
	logic [2:0] age_span;

	always_comb begin
		nxt_inj_super = 1'b0;
		nxt_inj_q = inj_q_ff;
		nxt_cls = cls_ff;
		nxt_len = len_ff;
		if (INJ_VALID) begin
			nxt_inj_super = INJ_SUPER_PRIORITY_FLAG; // [R10]
			nxt_inj_q = INJ_DROP_PRECEDENCE[0]; // [R10]
		end
		if (COPY_VALID) begin
			nxt_cls = CPU_COPY_CLASS_SELECT[COPY_PORT] ? COPY_CFG_CLASS : COPY_EXTRACT_QUEUE; // [R11]
			nxt_len = COPY_LEN;
			if (COPY_LEARNALL && LEARNALL_TRUNCATE_ENABLE[COPY_PORT] && COPY_LEN > `TRUNC_LEN) begin
				nxt_len = `TRUNC_LEN; // [R12]
			end
		end
		// epoch wraps at 8 ticks; frames older than that are lost from view
		age_span = epoch - DEQ_EPOCH;
		aged = !AGING_CHECK_DISABLE[DEQ_EV.port]
			&& (FLUSH_AS_STALE_ENABLE || age_span >= `AGE_STALE_TICKS); // [R06] [R07]
		nxt_send = run && DEQ_EV.valid && PORT_SWITCHING_ENABLE[DEQ_EV.port] && !aged; // [R04]
		nxt_drop = run && DEQ_EV.valid && PORT_SWITCHING_ENABLE[DEQ_EV.port] && aged; // [R06]
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			inj_super_ff <= 1'b0;
			inj_q_ff <= 1'b0;
			cls_ff <= 3'h0;
			len_ff <= 14'h0000;
			send_ff <= 1'b0;
			drop_ff <= 1'b0;
		end else begin
			inj_super_ff <= nxt_inj_super;
			inj_q_ff <= nxt_inj_q;
			cls_ff <= nxt_cls;
			len_ff <= nxt_len;
			send_ff <= nxt_send;
			drop_ff <= nxt_drop;
		end
	end

	assign INJ_TO_SUPER = inj_super_ff;
	assign INJ_SP_QUEUE = inj_q_ff;
	assign COPY_CLASS = cls_ff;
	assign COPY_OUT_LEN = len_ff;
	assign DEQ_SEND = send_ff;
	assign DEQ_DISCARD = drop_ff;

	// statistics
	qhk_pkg::counter_t rx_ff [`QHK_PORTS][`QHK_SET];
	qhk_pkg::counter_t drop_ff_c [`QHK_PORTS][`QHK_SET];
	qhk_pkg::counter_t tx_ff [`QHK_PORTS][`QHK_SET];
	qhk_pkg::counter_t tail_ff [`QHK_PORTS];
	qhk_pkg::counter_t abort_ff [`QHK_PORTS];
	logic [`SRV_ALL_W-1:0] sdrop_ff [`QHK_SRV][2];
	logic [`SRV_ALL_W-1:0] stx_ff [`QHK_SRV][2];
	qhk_pkg::counter_t nxt_rx [`QHK_PORTS][`QHK_SET];
	qhk_pkg::counter_t nxt_drop_c [`QHK_PORTS][`QHK_SET];
	qhk_pkg::counter_t nxt_tx [`QHK_PORTS][`QHK_SET];
	qhk_pkg::counter_t nxt_tail [`QHK_PORTS];
	qhk_pkg::counter_t nxt_abort [`QHK_PORTS];
	logic [`SRV_ALL_W-1:0] nxt_sdrop [`QHK_SRV][2];
	logic [`SRV_ALL_W-1:0] nxt_stx [`QHK_SRV][2];
	logic [31:0] win_ff, nxt_win;

	function automatic qhk_pkg::counter_t cnt_add(qhk_pkg::counter_t c, logic [13:0] len);
		qhk_pkg::counter_t r;
		r.frames = c.frames + 32'h1; // [R13]
		r.octets = c.octets + {26'h0, len}; // [R13]
		return r;
	endfunction

	function automatic logic [`SRV_ALL_W-1:0] srv_add(logic [`SRV_ALL_W-1:0] c,
		logic [13:0] len, logic only_frames);
		logic [`SRV_ALL_W-1:0] r;
		r = c;
		if (only_frames) begin
			r = c + 28'h1; // [R23]
		end else begin
			r[`SRV_FRM_W-1:0] = c[`SRV_FRM_W-1:0] + 10'h1; // [R23]
			r[`SRV_ALL_W-1:`SRV_FRM_W] = c[`SRV_ALL_W-1:`SRV_FRM_W] + {4'h0, len};
		end
		return r;
	endfunction

	logic [3:0] rx_set, drop_set, tx_set;
	logic [1:0] drop_port;
	logic drop_count, deq_send_now, deq_aged_now;

	always_comb begin
		nxt_rx = rx_ff;
		nxt_drop_c = drop_ff_c;
		nxt_tx = tx_ff;
		nxt_tail = tail_ff;
		nxt_abort = abort_ff;
		nxt_sdrop = sdrop_ff;
		nxt_stx = stx_ff;
		rx_set = {PRECEDENCE_TO_COLOR_MAP[RX_EV.dp], RX_EV.qos}; // [R15]
		drop_set = {PRECEDENCE_TO_COLOR_MAP[DISCARD_EV.dp], DISCARD_EV.qos}; // [R15]
		tx_set = {PRECEDENCE_TO_COLOR_MAP[DEQ_EV.dp], DEQ_EV.qos}; // [R15]
		drop_port = DROP_COUNT_EGRESS ? DISCARD_EGRESS_PORT : DISCARD_EV.port; // [R22]
		drop_count = run && DISCARD_EV.valid && DISCARD_REACHED_NONE && !DISCARD_IS_COPY; // [R14]
		deq_send_now = nxt_send;
		deq_aged_now = nxt_drop;
		if (run && RX_EV.valid && PORT_SWITCHING_ENABLE[RX_EV.port]) begin
			nxt_rx[RX_EV.port][rx_set] = cnt_add(rx_ff[RX_EV.port][rx_set], RX_EV.len);
		end
		if (drop_count) begin
			nxt_drop_c[drop_port][drop_set] = cnt_add(drop_ff_c[drop_port][drop_set],
				DISCARD_EV.len); // [R14]
			nxt_sdrop[DISCARD_EV.srv][drop_set[3]] = srv_add(sdrop_ff[DISCARD_EV.srv][drop_set[3]],
				DISCARD_EV.len, SERVICE_FRAMES_ONLY); // [R18]
		end
		if (run && TAIL_DROP_VALID) begin
			nxt_tail[TAIL_DROP_PORT].frames = tail_ff[TAIL_DROP_PORT].frames + 32'h1;
		end
		if (deq_send_now) begin
			nxt_tx[DEQ_EV.port][tx_set] = cnt_add(tx_ff[DEQ_EV.port][tx_set], DEQ_EV.len); // [R16]
			nxt_stx[DEQ_EV.srv][tx_set[3]] = srv_add(stx_ff[DEQ_EV.srv][tx_set[3]],
				DEQ_EV.len, SERVICE_FRAMES_ONLY); // [R18]
		end
		// all three abort sources may hit one port in the same cycle
		for (int p = 0; p < `QHK_PORTS; p++) begin
			if (deq_aged_now && DEQ_EV.port == 2'(p)) begin
				nxt_abort[p] = cnt_add(nxt_abort[p], DEQ_EV.len); // [R17]
			end
			if (run && FLUSH_EV.valid && FLUSH_EV.port == 2'(p)) begin
				nxt_abort[p] = cnt_add(nxt_abort[p], FLUSH_EV.len); // [R17]
			end
			if (run && ABORT_EV.valid && ABORT_EV.port == 2'(p)) begin
				nxt_abort[p] = cnt_add(nxt_abort[p], ABORT_EV.len); // [R17]
			end
		end
		// clearing wins over a same-cycle count on the cleared set
		for (int s = 0; s < `QHK_SET; s++) begin
			if (init_busy || STAT_CLEAR) begin
				nxt_rx[init_busy ? init_idx[1:0] : STAT_VIEW[1:0]][s] = '0; // [R01] [R19]
				nxt_drop_c[init_busy ? init_idx[1:0] : STAT_VIEW[1:0]][s] = '0;
				nxt_tx[init_busy ? init_idx[1:0] : STAT_VIEW[1:0]][s] = '0;
			end
		end
		if (init_busy || STAT_CLEAR) begin
			nxt_tail[init_busy ? init_idx[1:0] : STAT_VIEW[1:0]] = '0;
			nxt_abort[init_busy ? init_idx[1:0] : STAT_VIEW[1:0]] = '0;
			for (int c = 0; c < 2; c++) begin
				nxt_sdrop[init_busy ? init_idx : STAT_VIEW][c] = '0; // [R19]
				nxt_stx[init_busy ? init_idx : STAT_VIEW][c] = '0;
			end
		end
	end

	// window read, one cycle latency
	qhk_pkg::counter_t sel_cnt;
	logic [`SRV_ALL_W-1:0] sel_srv;
	logic sel_is_srv, sel_hit;
	logic [5:0] widx;

	always_comb begin
		widx = WINDOW_ADDR[5:0];
		sel_cnt = '0;
		sel_srv = '0;
		sel_is_srv = 1'b0;
		sel_hit = 1'b1;
		case (WINDOW_ADDR[9:8]) // [R20]
			`GRP_PORT_RX: begin
				if (widx < `IDX_DROP_BASE) begin
					sel_cnt = rx_ff[STAT_VIEW[1:0]][widx[3:0]];
				end else if (widx < `IDX_TAIL) begin
					sel_cnt = drop_ff_c[STAT_VIEW[1:0]][widx[3:0]];
				end else if (widx == `IDX_TAIL) begin
					sel_cnt = tail_ff[STAT_VIEW[1:0]];
				end else begin
					sel_hit = 1'b0;
				end
			end
			`GRP_PORT_TX: begin
				if (widx < `IDX_ABORT) begin
					sel_cnt = tx_ff[STAT_VIEW[1:0]][widx[3:0]];
				end else if (widx == `IDX_ABORT) begin
					sel_cnt = abort_ff[STAT_VIEW[1:0]];
				end else begin
					sel_hit = 1'b0;
				end
			end
			`GRP_SRV_DROP: begin
				sel_is_srv = 1'b1;
				sel_hit = (widx[5:1] == 5'h00);
				sel_srv = sdrop_ff[STAT_VIEW][widx[0]];
			end
			`GRP_SRV_TX: begin
				sel_is_srv = 1'b1;
				sel_hit = (widx[5:1] == 5'h00);
				sel_srv = stx_ff[STAT_VIEW][widx[0]];
			end
			default: sel_hit = 1'b0;
		endcase
		if (sel_is_srv) begin
			sel_cnt.frames = SERVICE_FRAMES_ONLY ? {4'h0, sel_srv}
				: {22'h0, sel_srv[`SRV_FRM_W-1:0]}; // [R23]
			sel_cnt.octets = SERVICE_FRAMES_ONLY ? 40'h0
				: {22'h0, sel_srv[`SRV_ALL_W-1:`SRV_FRM_W]};
		end
		nxt_win = 32'h0;
		if (sel_hit) begin
			case (WINDOW_ADDR[7:6]) // [R21]
				`KIND_FRM: nxt_win = sel_cnt.frames;
				`KIND_OCT_LO: nxt_win = sel_cnt.octets[31:0];
				`KIND_OCT_HI: nxt_win = {24'h0, sel_cnt.octets[39:32]};
				default: nxt_win = 32'h0;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rx_ff <= '{default: '0};
			drop_ff_c <= '{default: '0};
			tx_ff <= '{default: '0};
			tail_ff <= '{default: '0};
			abort_ff <= '{default: '0};
			sdrop_ff <= '{default: '0};
			stx_ff <= '{default: '0};
			win_ff <= 32'h0;
		end else begin
			rx_ff <= nxt_rx;
			drop_ff_c <= nxt_drop_c;
			tx_ff <= nxt_tx;
			tail_ff <= nxt_tail;
			abort_ff <= nxt_abort;
			sdrop_ff <= nxt_sdrop;
			stx_ff <= nxt_stx;
			win_ff <= nxt_win;
		end
	end

	assign WINDOW_DATA = win_ff; // [R19]
endmodule

/* File: verilog/qhk_defs.svh */
// constants for the queue housekeeping block
// Notes on behaviour
// (R01) enable then init bit: hardware initializes all tables
// (R02) software waits, then raises core enable
// (R03) hardware clears init bit when done
// (R04) per-port enable gates all switching
// (R05) periodic aging tick from configured period
// (R06) ticks mark frames; stale frames dropped at dequeue
// (R07) per-port aging disable; flush treats frames stale
// (R08) super-priority queues win over all others
// (R09) sp0 bypasses shaper; sp1 obeys and charges
// (R10) cpu inject flag uses precedence as sp queue
// (R11) per-port mode picks cpu copy class source
// (R12) learn-all copies truncated to 64 bytes
// (R13) counter is 40-bit octets, 32-bit frames
// (R14) discard only when no destination reached
// (R15) color green/yellow via precedence map
// (R16) transmit counted per egress port, class, color
// (R17) abort counter: aging, flushing, rewriter abort
// (R18) service counters per index and color
// (R19) view select, clear, 1024-entry window read
// (R20) window frame counter address layout
// (R21) octets at plus 64 low, plus 128 high
// (R22) drop counting from ingress or egress view
// (R23) service 10/18 split or 28-bit frames only
`ifndef QHK_DEFS_SVH
`define QHK_DEFS_SVH
`define QHK_PORTS 4
`define QHK_SRV 16
`define QHK_SET 16
`define INIT_LAST 4'hF
`define CLK_NS 10
`define AGE_UNIT_NS 1000
`define AGE_UNIT_CYC ((`AGE_UNIT_NS + `CLK_NS - 1) / `CLK_NS)
`define AGE_STALE_TICKS 3'h2
`define TRUNC_LEN 14'h0040
`define GRP_PORT_RX 2'h0
`define GRP_PORT_TX 2'h1
`define GRP_SRV_DROP 2'h2
`define GRP_SRV_TX 2'h3
`define KIND_FRM 2'h0
`define KIND_OCT_LO 2'h1
`define KIND_OCT_HI 2'h2
`define IDX_DROP_BASE 6'h10
`define IDX_TAIL 6'h20
`define IDX_ABORT 6'h10
`define SRV_FRM_W 10
`define SRV_OCT_W 18
`define SRV_ALL_W 28
`endif

/* File: verilog/qhk_pkg.sv */
// types shared by the queue housekeeping block
package qhk_pkg;
	typedef struct packed {
		logic [39:0] octets;
		logic [31:0] frames;
	} counter_t;
	typedef struct packed {
		logic valid;
		logic [1:0] port;
		logic [2:0] qos;
		logic [1:0] dp;
		logic [13:0] len;
		logic [3:0] srv;
	} frame_event_t;
	typedef enum logic [1:0] {
		INIT_IDLE = 2'b00,
		INIT_RUN = 2'b01
	} init_state_t;
	typedef enum logic [1:0] {
		SEL_NONE = 2'b00,
		SEL_SP0 = 2'b01,
		SEL_SP1 = 2'b10,
		SEL_NORMAL = 2'b11
	} sel_kind_t;
endpackage

/* File: verilog/mem_init.sv */
// memory initialization sequencer
`timescale 1ns/1ns
`include "qhk_defs.svh"
module mem_init (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic memory_enable,
	input wire logic init_set,
	output logic init_busy,
	output logic [3:0] init_idx
);
	qhk_pkg::init_state_t state_ff, nxt_state;
	logic [3:0] idx_ff, nxt_idx;

	always_comb begin
		nxt_state = state_ff;
		nxt_idx = idx_ff;
		case (state_ff)
			qhk_pkg::INIT_IDLE: begin
				if (memory_enable && init_set) begin // [R01]
					nxt_state = qhk_pkg::INIT_RUN;
					nxt_idx = 4'h0;
				end
			end
			qhk_pkg::INIT_RUN: begin
				if (idx_ff == `INIT_LAST) begin
					nxt_state = qhk_pkg::INIT_IDLE; // [R03]
				end else begin
					nxt_idx = idx_ff + 4'h1; // [R01]
				end
			end
			default: nxt_state = qhk_pkg::INIT_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= qhk_pkg::INIT_IDLE;
			idx_ff <= 4'h0;
		end else begin
			state_ff <= nxt_state;
			idx_ff <= nxt_idx;
		end
	end

	assign init_busy = (state_ff == qhk_pkg::INIT_RUN);
	assign init_idx = idx_ff;
endmodule

/* File: verilog/age_tick.sv */
// periodic aging tick and tick epoch
`timescale 1ns/1ns
`include "qhk_defs.svh"
module age_tick (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [15:0] aging_period,
	output logic tick,
	output logic [2:0] epoch
);
	logic [15:0] pre_ff, nxt_pre;
	logic [15:0] unit_ff, nxt_unit;
	logic tick_ff, nxt_tick;
	logic [2:0] epoch_ff, nxt_epoch;

	// period in microsecond units; zero stops the tick and holds the epoch
	always_comb begin
		nxt_pre = pre_ff;
		nxt_unit = unit_ff;
		nxt_tick = 1'b0;
		nxt_epoch = epoch_ff;
		if (aging_period == 16'h0000) begin
			nxt_pre = 16'h0000;
			nxt_unit = 16'h0000;
		end else if (pre_ff == 16'(`AGE_UNIT_CYC - 1)) begin
			nxt_pre = 16'h0000;
			if (unit_ff >= aging_period - 16'h0001) begin // [R05]
				nxt_unit = 16'h0000;
				nxt_tick = 1'b1;
				nxt_epoch = epoch_ff + 3'h1;
			end else begin
				nxt_unit = unit_ff + 16'h0001;
			end
		end else begin
			nxt_pre = pre_ff + 16'h0001;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pre_ff <= 16'h0000;
			unit_ff <= 16'h0000;
			tick_ff <= 1'b0;
			epoch_ff <= 3'h0;
		end else begin
			pre_ff <= nxt_pre;
			unit_ff <= nxt_unit;
			tick_ff <= nxt_tick;
			epoch_ff <= nxt_epoch;
		end
	end

	assign tick = tick_ff;
	assign epoch = epoch_ff;
endmodule

/* File: sim/qhk_checker.sv */
// assertion checker for the queue housekeeping ports
`timescale 1ns/1ns
module qhk_checker (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic MEMORY_ENABLE,
	input wire logic MEMORY_INIT_SET,
	input wire logic MEMORY_INIT,
	input wire logic CORE_ENABLE,
	input wire logic [3:0] PORT_SWITCHING_ENABLE,
	input wire logic AGE_TICK,
	input wire logic [2:0] AGE_EPOCH,
	input wire logic [1:0] SCHED_PORT,
	input wire logic [1:0] SP_PENDING,
	input wire logic SHAPER_OPEN,
	input wire qhk_pkg::sel_kind_t SEL_KIND,
	input wire logic SHAPER_CHARGE,
	input wire logic INJ_VALID,
	input wire logic INJ_SUPER_PRIORITY_FLAG,
	input wire logic [1:0] INJ_DROP_PRECEDENCE,
	input wire logic INJ_TO_SUPER,
	input wire logic INJ_SP_QUEUE,
	input wire qhk_pkg::frame_event_t DEQ_EV,
	input wire logic [2:0] DEQ_EPOCH,
	input wire logic DEQ_SEND,
	input wire logic DEQ_DISCARD,
	input wire logic FLUSH_AS_STALE_ENABLE,
	input wire logic [3:0] AGING_CHECK_DISABLE
);
	logic run;
	logic deq_go;
	// events count only while the core runs and init is over
	assign run = CORE_ENABLE && !MEMORY_INIT;
	assign deq_go = run && DEQ_EV.valid && PORT_SWITCHING_ENABLE[DEQ_EV.port];
	default clocking @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	property p_init_go;
		MEMORY_ENABLE && MEMORY_INIT_SET && !MEMORY_INIT |=> MEMORY_INIT;
	endproperty
	a_init_go: assert property (p_init_go) else $error("init not started");
	property p_init_len;
		$rose(MEMORY_INIT) |-> ##15 MEMORY_INIT ##1 !MEMORY_INIT;
	endproperty
	a_init_len: assert property (p_init_len) else $error("init length wrong");
	property p_tick_gap;
		AGE_TICK |=> !AGE_TICK [*8];
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");
	property p_epoch;
		AGE_EPOCH != $past(AGE_EPOCH) |-> AGE_EPOCH == $past(AGE_EPOCH) + 3'h1;
	endproperty
	a_epoch: assert property (p_epoch) else $error("epoch step wrong");
	property p_sp0;
		run && SP_PENDING[0] && PORT_SWITCHING_ENABLE[SCHED_PORT]
			|-> SEL_KIND == qhk_pkg::SEL_SP0 && !SHAPER_CHARGE;
	endproperty
	a_sp0: assert property (p_sp0) else $error("sp0 not first");
	property p_sp1;
		run && SP_PENDING == 2'h2 && SHAPER_OPEN && PORT_SWITCHING_ENABLE[SCHED_PORT]
			|-> SEL_KIND == qhk_pkg::SEL_SP1 && SHAPER_CHARGE;
	endproperty
	a_sp1: assert property (p_sp1) else $error("sp1 select wrong");
	property p_inj;
		run && INJ_VALID && INJ_SUPER_PRIORITY_FLAG
			|=> INJ_TO_SUPER && INJ_SP_QUEUE == $past(INJ_DROP_PRECEDENCE[0]);
	endproperty
	a_inj: assert property (p_inj) else $error("inject queue wrong");
	property p_flush;
		deq_go && FLUSH_AS_STALE_ENABLE && !AGING_CHECK_DISABLE[DEQ_EV.port]
			|=> DEQ_DISCARD && !DEQ_SEND;
	endproperty
	a_flush: assert property (p_flush) else $error("flush not dropped");
	property p_fresh;
		deq_go && !FLUSH_AS_STALE_ENABLE && DEQ_EPOCH == AGE_EPOCH |=> DEQ_SEND && !DEQ_DISCARD;
	endproperty
	a_fresh: assert property (p_fresh) else $error("fresh not sent");
	c_init: cover property ($rose(MEMORY_INIT));
	c_tick: cover property (AGE_TICK);
	c_aged: cover property (DEQ_DISCARD);
endmodule
bind queue_housekeeping qhk_checker qhk_checker_i (.CLK, .ARST_N, .MEMORY_ENABLE,
	.MEMORY_INIT_SET, .MEMORY_INIT, .CORE_ENABLE, .PORT_SWITCHING_ENABLE, .AGE_TICK,
	.AGE_EPOCH, .SCHED_PORT, .SP_PENDING, .SHAPER_OPEN, .SEL_KIND, .SHAPER_CHARGE,
	.INJ_VALID, .INJ_SUPER_PRIORITY_FLAG, .INJ_DROP_PRECEDENCE, .INJ_TO_SUPER,
	.INJ_SP_QUEUE, .DEQ_EV, .DEQ_EPOCH, .DEQ_SEND, .DEQ_DISCARD, .FLUSH_AS_STALE_ENABLE,
	.AGING_CHECK_DISABLE);

/* File: sim/qhk_sw.sv */
// software-side partner: memory bring-up then core enable
`timescale 1ns/1ns
module qhk_sw (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic MEMORY_INIT,
	output logic MEMORY_ENABLE,
	output logic MEMORY_INIT_SET,
	output logic CORE_ENABLE
);
	initial begin
		MEMORY_ENABLE = 1'b0;
		MEMORY_INIT_SET = 1'b0;
		CORE_ENABLE = 1'b0;
		wait (ARST_N === 1'b1);
		@(negedge CLK);
		MEMORY_ENABLE = 1'b1;
		@(negedge CLK);
		MEMORY_INIT_SET = 1'b1;
		@(negedge CLK);
		MEMORY_INIT_SET = 1'b0;
		// poll bounded by the 150 us alternative wait
		repeat (15000) begin
			@(negedge CLK);
			if (MEMORY_INIT === 1'b0) break;
		end
		CORE_ENABLE = 1'b1;
	end
endmodule

/* File: sim/tb.sv */
// self-checking bench for the queue housekeeping block
`timescale 1ns/1ns
module tb;
	typedef struct {logic [9:0] a; logic [31:0] d;} row_t;
	logic CLK = 1'b0;
	logic ARST_N = 1'b0;
	wire logic MEMORY_ENABLE, MEMORY_INIT_SET, CORE_ENABLE;
	logic FLUSH_AS_STALE_ENABLE = 1'b0, SHAPER_OPEN = 1'b1, INJ_VALID = 1'b0;
	logic INJ_SUPER_PRIORITY_FLAG = 1'b1, COPY_VALID = 1'b0, COPY_LEARNALL = 1'b1;
	logic DISCARD_REACHED_NONE = 1'b1, DISCARD_IS_COPY = 1'b0, DROP_COUNT_EGRESS = 1'b0;
	logic TAIL_DROP_VALID = 1'b0, STAT_CLEAR = 1'b0, SERVICE_FRAMES_ONLY = 1'b0;
	logic [1:0] SCHED_PORT = 2'h1, SP_PENDING = 2'h0, INJ_DROP_PRECEDENCE = 2'h1;
	logic [1:0] COPY_PORT = 2'h0, DISCARD_EGRESS_PORT = 2'h1, TAIL_DROP_PORT = 2'h1;
	logic [2:0] COPY_EXTRACT_QUEUE = 3'h1, COPY_CFG_CLASS = 3'h6, DEQ_EPOCH = 3'h0;
	logic [3:0] PORT_SWITCHING_ENABLE = 4'hF, AGING_CHECK_DISABLE = 4'h0;
	logic [3:0] CPU_COPY_CLASS_SELECT = 4'h3, LEARNALL_TRUNCATE_ENABLE = 4'h5;
	logic [3:0] PRECEDENCE_TO_COLOR_MAP = 4'hC, STAT_VIEW = 4'h1;
	logic [7:0] QUEUE_PENDING = 8'h24;
	logic [9:0] WINDOW_ADDR = 10'h000;
	logic [13:0] COPY_LEN = 14'h0064;
	logic [15:0] AGING_PERIOD = 16'h0000;
	qhk_pkg::frame_event_t RX_EV = '0, DISCARD_EV = '0, DEQ_EV = '0, FLUSH_EV = '0;
	qhk_pkg::frame_event_t ABORT_EV = '0;
	logic MEMORY_INIT, AGE_TICK, SHAPER_CHARGE, INJ_TO_SUPER, INJ_SP_QUEUE;
	logic DEQ_SEND, DEQ_DISCARD, snd, dsc;
	logic [2:0] AGE_EPOCH, SEL_QUEUE, COPY_CLASS;
	logic [13:0] COPY_OUT_LEN;
	logic [31:0] WINDOW_DATA;
	qhk_pkg::sel_kind_t SEL_KIND;
	int error_cnt = 0, compares = 0, cyc = 0, n;
	// viewed set is port 1 and service 1; map makes precedence 2 and 3 yellow
	row_t rows[] = '{'{10'h003, 32'h1}, '{10'h043, 32'h64}, '{10'h083, 32'h0},
		'{10'h00D, 32'h1}, '{10'h04D, 32'hC8}, '{10'h102, 32'h1}, '{10'h142, 32'h12C},
		'{10'h10A, 32'h1}, '{10'h14A, 32'h28}, '{10'h110, 32'h4}, '{10'h150, 32'h64},
		'{10'h01C, 32'h1}, '{10'h05C, 32'h40}, '{10'h010, 32'h1}, '{10'h050, 32'h46},
		'{10'h020, 32'h1}, '{10'h300, 32'h1}, '{10'h340, 32'h12C}, '{10'h301, 32'h1},
		'{10'h201, 32'h1}, '{10'h200, 32'h1}, '{10'h3E8, 32'h0}};
	queue_housekeeping queue_housekeeping_i (.CLK, .ARST_N, .MEMORY_ENABLE, .MEMORY_INIT_SET,
		.MEMORY_INIT, .CORE_ENABLE, .PORT_SWITCHING_ENABLE, .AGING_PERIOD, .AGING_CHECK_DISABLE,
		.FLUSH_AS_STALE_ENABLE, .AGE_TICK, .AGE_EPOCH, .SCHED_PORT, .QUEUE_PENDING, .SP_PENDING,
		.SHAPER_OPEN, .SEL_KIND, .SEL_QUEUE, .SHAPER_CHARGE, .INJ_VALID,
		.INJ_SUPER_PRIORITY_FLAG, .INJ_DROP_PRECEDENCE, .INJ_TO_SUPER, .INJ_SP_QUEUE,
		.COPY_VALID, .COPY_PORT, .COPY_EXTRACT_QUEUE, .COPY_CFG_CLASS, .COPY_LEARNALL,
		.COPY_LEN, .CPU_COPY_CLASS_SELECT, .LEARNALL_TRUNCATE_ENABLE, .COPY_CLASS,
		.COPY_OUT_LEN, .RX_EV, .DISCARD_EV, .DISCARD_EGRESS_PORT, .DISCARD_REACHED_NONE,
		.DISCARD_IS_COPY, .DROP_COUNT_EGRESS, .TAIL_DROP_VALID, .TAIL_DROP_PORT, .DEQ_EV,
		.DEQ_EPOCH, .DEQ_SEND, .DEQ_DISCARD, .FLUSH_EV, .ABORT_EV, .PRECEDENCE_TO_COLOR_MAP,
		.STAT_VIEW, .STAT_CLEAR, .SERVICE_FRAMES_ONLY, .WINDOW_ADDR, .WINDOW_DATA);
	qhk_sw qhk_sw_i (.CLK, .ARST_N, .MEMORY_INIT, .MEMORY_ENABLE, .MEMORY_INIT_SET,
		.CORE_ENABLE);
	initial begin
		forever #5 CLK = ~CLK;
	end
	task close_out;
		$display("counts: %0d compares, %0d mismatches", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// run is a few hundred cycles; the ceiling leaves ample margin
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			close_out;
		end
	end
	task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %0h seen %0h", s, exp, seen);
		end
	endtask
	function qhk_pkg::frame_event_t mk(input logic [1:0] p, input logic [2:0] q,
		input logic [1:0] d, input logic [13:0] l);
		return '{1'b1, p, q, d, l, 4'h1};
	endfunction
	// one-cycle event; deq answer is sampled while it stands
	task fire(input int k, input qhk_pkg::frame_event_t e);
		@(negedge CLK);
		case (k)
			0: RX_EV = e;
			1: DISCARD_EV = e;
			2: DEQ_EV = e;
			3: FLUSH_EV = e;
			default: ABORT_EV = e;
		endcase
		@(negedge CLK);
		snd = DEQ_SEND;
		dsc = DEQ_DISCARD;
		{RX_EV, DISCARD_EV, DEQ_EV, FLUSH_EV, ABORT_EV} = '0;
	endtask
	task rd(input logic [9:0] a, input logic [31:0] exp);
		@(negedge CLK);
		WINDOW_ADDR = a;
		@(negedge CLK);
		chk($sformatf("window %0d", a), WINDOW_DATA, exp);
	endtask
	task pulse_tail;
		@(negedge CLK);
		TAIL_DROP_VALID = 1'b1;
		@(negedge CLK);
		TAIL_DROP_VALID = 1'b0;
	endtask
	initial begin
		repeat (6) @(posedge CLK);
		@(negedge CLK);
		ARST_N = 1'b1;
		chk("init idle", MEMORY_INIT, 1'h0);
		n = 0;
		while (CORE_ENABLE !== 1'b1 && n < 20000) begin
			@(negedge CLK);
			n++;
		end
		chk("init done", MEMORY_INIT, 1'h0);
		fire(0, mk(2'h1, 3'h3, 2'h0, 14'h0064));
		fire(0, mk(2'h1, 3'h5, 2'h2, 14'h00C8));
		PORT_SWITCHING_ENABLE = 4'hD;
		fire(0, mk(2'h1, 3'h3, 2'h0, 14'h0064));
		PORT_SWITCHING_ENABLE = 4'hF;
		DEQ_EPOCH = AGE_EPOCH - 3'h1;
		fire(2, mk(2'h1, 3'h2, 2'h0, 14'h012C));
		chk("fresh deq", {snd, dsc}, 2'h2);
		DEQ_EPOCH = AGE_EPOCH - 3'h2;
		fire(2, mk(2'h1, 3'h2, 2'h0, 14'h000A));
		chk("aged deq", {snd, dsc}, 2'h1);
		FLUSH_AS_STALE_ENABLE = 1'b1;
		DEQ_EPOCH = AGE_EPOCH;
		fire(2, mk(2'h1, 3'h2, 2'h0, 14'h0014));
		chk("flush deq", {snd, dsc}, 2'h1);
		AGING_CHECK_DISABLE = 4'h2;
		DEQ_EPOCH = AGE_EPOCH - 3'h3;
		fire(2, mk(2'h1, 3'h2, 2'h3, 14'h0028));
		chk("no-age deq", {snd, dsc}, 2'h2);
		FLUSH_AS_STALE_ENABLE = 1'b0;
		AGING_CHECK_DISABLE = 4'h0;
		fire(4, mk(2'h1, 3'h0, 2'h0, 14'h0032));
		fire(3, mk(2'h1, 3'h0, 2'h0, 14'h0014));
		fire(1, mk(2'h1, 3'h4, 2'h3, 14'h0040));
		DISCARD_IS_COPY = 1'b1;
		fire(1, mk(2'h1, 3'h4, 2'h3, 14'h0040));
		DISCARD_IS_COPY = 1'b0;
		DISCARD_REACHED_NONE = 1'b0;
		fire(1, mk(2'h1, 3'h4, 2'h3, 14'h0040));
		DISCARD_REACHED_NONE = 1'b1;
		DROP_COUNT_EGRESS = 1'b1;
		fire(1, mk(2'h0, 3'h0, 2'h0, 14'h0046));
		DROP_COUNT_EGRESS = 1'b0;
		pulse_tail;
		foreach (rows[i]) rd(rows[i].a, rows[i].d);
		$display("test counters done");
		@(negedge CLK);
		STAT_CLEAR = 1'b1;
		@(negedge CLK);
		STAT_CLEAR = 1'b0;
		rd(10'h003, 32'h0);
		SERVICE_FRAMES_ONLY = 1'b1;
		DEQ_EPOCH = AGE_EPOCH;
		fire(2, mk(2'h1, 3'h2, 2'h0, 14'h012C));
		rd(10'h300, 32'h1);
		rd(10'h340, 32'h0);
		$display("test clear and service done");
		for (int i = 0; i < 4; i++) begin
			@(negedge CLK);
			SP_PENDING = 2'(i);
			#1;
			chk("sel", SEL_KIND, i[0] ? qhk_pkg::SEL_SP0 : i[1] ? qhk_pkg::SEL_SP1
				: qhk_pkg::SEL_NORMAL);
			chk("charge", SHAPER_CHARGE, !i[0]);
			if (i == 0) chk("queue", SEL_QUEUE, 3'h5);
		end
		@(negedge CLK);
		SHAPER_OPEN = 1'b0;
		#1;
		chk("sp0 shut", SEL_KIND, qhk_pkg::SEL_SP0);
		@(negedge CLK);
		SP_PENDING = 2'h2;
		#1;
		chk("sp1 shut", SEL_KIND, qhk_pkg::SEL_NONE);
		for (int k = 0; k < 4; k++) begin
			@(negedge CLK);
			COPY_PORT = 2'(k);
			COPY_VALID = 1'b1;
			@(negedge CLK);
			COPY_VALID = 1'b0;
			chk("copy class", COPY_CLASS, k < 2 ? 3'h6 : 3'h1);
			chk("copy len", COPY_OUT_LEN, k[0] ? 14'h0064 : 14'h0040);
		end
		@(negedge CLK);
		INJ_VALID = 1'b1;
		@(negedge CLK);
		INJ_VALID = 1'b0;
		chk("inject", {INJ_TO_SUPER, INJ_SP_QUEUE}, 2'h3);
		@(negedge CLK);
		INJ_VALID = 1'b1;
		INJ_DROP_PRECEDENCE = 2'h2;
		@(negedge CLK);
		INJ_VALID = 1'b0;
		chk("inject sp0", {INJ_TO_SUPER, INJ_SP_QUEUE}, 2'h2);
		$display("test select done");
		AGING_PERIOD = 16'h0001;
		repeat (2) begin
			n = 0;
			do begin
				@(negedge CLK);
				n++;
			end while (AGE_TICK !== 1'b1 && n < 300);
		end
		chk("tick gap", n, 32'h64);
		$display("test tick done");
		@(negedge CLK);
		ARST_N = 1'b0;
		@(negedge CLK);
		chk("rst epoch", AGE_EPOCH, 3'h0);
		ARST_N = 1'b1;
		rd(10'h300, 32'h0);
		$display("test reset done");
		close_out;
	end
endmodule
